// File: inc/sil_pkg.sv
// package of constants and types for the safety interlock controller
package sil_pkg;
  // time base: one millisecond tick derived from the 100 MHz clock
  localparam int CLOCK_PERIOD_NS = 10;
  localparam int TICK_PERIOD_NS = 1_000_000;
  localparam int TICK_CYCLES = TICK_PERIOD_NS / CLOCK_PERIOD_NS;
  // supervision times in their own units, and in ticks
  localparam int WARN_MIN = 30;
  localparam int TEACH_S = 10;
  localparam int POWEROFF_MIN = 5;
  localparam int INHIBIT_MIN = 10;
  localparam logic [20:0] WARN_TICKS = 21'(WARN_MIN * 60 * 1000);
  localparam logic [20:0] TEACH_TICKS = 21'(TEACH_S * 1000);
  localparam logic [20:0] POWEROFF_TICKS = 21'(POWEROFF_MIN * 60 * 1000);
  localparam logic [20:0] INHIBIT_TICKS = 21'(INHIBIT_MIN * 60 * 1000);
  // blink generator periods in ticks
  localparam logic [9:0] HZ1_PERIOD = 10'h03e8;
  localparam logic [9:0] HZ1_ON = 10'h01f4;
  localparam logic [8:0] HZ3_PERIOD = 9'h014d;
  localparam logic [8:0] HZ3_ON = 9'h003c;
  localparam logic [8:0] SLOT_PERIOD = 9'h0190;
  localparam logic [8:0] SLOT_ON = 9'h00c8;
  // fault indicator pulse counts
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_OUT_A = 3'h1;
  localparam logic [2:0] CODE_OUT_B = 3'h2;
  localparam logic [2:0] CODE_CROSS = 3'h3;
  localparam logic [2:0] CODE_TEMP = 3'h4;
  localparam logic [2:0] CODE_ACTUATOR = 3'h5;
  localparam logic [2:0] CODE_HANDLE = 3'h6;
  localparam logic [2:0] CODE_INTERNAL = 3'h7;
  // fault cause bit positions
  localparam int CAUSE_OUT_A = 0;
  localparam int CAUSE_OUT_B = 1;
  localparam int CAUSE_CROSS = 2;
  localparam int CAUSE_TEMP = 3;

  // operating sequence
  typedef enum logic [2:0] {
    SIL_NORMAL = 3'b000,
    SIL_TEACH = 3'b001,
    SIL_OFFREQ = 3'b010,
    SIL_ABORT = 3'b011,
    SIL_COMMIT_WAIT = 3'b100,
    SIL_INHIBIT = 3'b101
  } sil_state_t;

  // pins that come from the outside world
  typedef struct packed {
    logic guard_closed;
    logic actuator_present;
    logic actuator_valid;
    logic lock_engaged;
    logic handle_ok;
  } sil_sense_t;

  // pins driven toward the outside world
  typedef struct packed {
    logic safety_output_a;
    logic safety_output_b;
    logic diag;
    logic solenoid_lock;
    logic led_power;
    logic led_status;
    logic led_fault;
    logic commit_code;
    logic nv_teach_pending;
    logic nv_inhibit_pending;
  } sil_drive_t;

  // whole state of the controller
  typedef struct packed {
    sil_state_t st;
    logic started;
    logic [16:0] tick_cnt;
    logic [9:0] ms_1hz;
    logic [8:0] ms_3hz;
    logic [8:0] slot_ms;
    logic [2:0] slot_idx;
    logic [20:0] timer;
    logic [20:0] warn_timer;
    logic warn;
    logic err;
    logic [2:0] code;
    logic req_prev;
    sil_drive_t drv;
  } sil_regs_t;
endpackage : sil_pkg

// File: core/sil_controller.sv
// control logic of the safety solenoid interlock
// Notes on behaviour
// - unlock variant: command asserted releases lock
// - lock variant: command asserted engages lock
// - coupled variant: unlocked drops outputs, relock restores
// - door-only variant: only guard opening drops outputs
// - minor fault warns, diag low, drops after 30min
// - latched error clears on guard opening
// - serial units accept telegram fault reset
// - internal fault drops outputs at once
// - warning clears itself when cause vanishes
// - actuator after power-up starts teach indication
// - after ten seconds status blinks 3 Hz
// - five minutes unpowered missing aborts, code five
// - commit code when actuator seen after repower
// - one-time variant refuses teach once committed
// - re-teachable variant repeats, new code replaces
// - ten minute inhibit after re-teach, power blinks
// - power loss restarts full inhibit period
// - no locking while handle between positions
// - power, status and fault indicators meanings
// - guard open all low; closed unlocked diag high
// - locking impossible: status blinks, diag low
// - closed and locked: status steady, all high
// - warning shows code; error drops everything
// - fault pulse count by cause, steady internal
// - serial reset on request bit falling edge
`timescale 1ns/1ps
module sil_controller #(
  parameter int TICK_CYCLES = sil_pkg::TICK_CYCLES // cycles per millisecond tick
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic rst_n_in,
  // variant straps
  input wire logic power_to_lock_variant_in,
  input wire logic lock_coupled_variant_in,
  input wire logic individually_coded_in,
  input wire logic reteachable_coding_variant_in,
  input wire logic serial_variant_in,
  // command and sensors
  input wire logic lock_cmd_in,
  input wire sil_pkg::sil_sense_t sense_in,
  input wire logic [3:0] fault_cause_in,
  input wire logic internal_fault_in,
  input wire logic reset_request_in,
  // persistent storage view
  input wire logic code_stored_in,
  input wire logic nv_teach_pending_in,
  input wire logic nv_inhibit_pending_in,
  // drives
  output sil_pkg::sil_drive_t drive_out
);

  sil_pkg::sil_regs_t q; // registered state
  sil_pkg::sil_regs_t d; // next state

  logic tick; // one-cycle millisecond strobe
  logic cause_any; // any minor fault present
  logic [2:0] cause_code; // pulse count for the present minor fault
  logic want_lock; // decoded lock request
  logic locked; // guard closed, actuator valid and bolt engaged
  logic enable_path; // outputs may be on in normal running
  logic frame_end; // fault code frame wraps
  logic red_code; // red blink pattern for q.code
  logic handle_bad_req; // lock requested with handle off position
  logic reset_req; // guard opening or serial reset edge

  assign drive_out = q.drv;

  // next-state logic
  always_comb
  begin
    d = q;
    d.drv.commit_code = 1'b0;
    // single time base for every timer and blinker
    tick = (q.tick_cnt == 17'(TICK_CYCLES - 1));
    d.tick_cnt = tick ? 17'h0_0000 : q.tick_cnt + 17'h0_0001;
    frame_end = 1'b0;
    if (tick)
    begin
      d.ms_1hz = (q.ms_1hz == sil_pkg::HZ1_PERIOD - 10'h001) ? 10'h000 : q.ms_1hz + 10'h001;
      d.ms_3hz = (q.ms_3hz == sil_pkg::HZ3_PERIOD - 9'h001) ? 9'h000 : q.ms_3hz + 9'h001;
      if (q.slot_ms == sil_pkg::SLOT_PERIOD - 9'h001)
      begin
        d.slot_ms = 9'h000;
        d.slot_idx = q.slot_idx + 3'h1;
        frame_end = (q.slot_idx == 3'h7);
      end
      else
      begin
        d.slot_ms = q.slot_ms + 9'h001;
      end
    end
    // decode of the magnet command, variant dependent
    want_lock = power_to_lock_variant_in ? lock_cmd_in : ~lock_cmd_in;
    handle_bad_req = want_lock & ~sense_in.handle_ok;
    locked = sense_in.guard_closed & sense_in.actuator_valid & sense_in.lock_engaged;
    // minor fault coding, cross short wins when both outputs are hit
    cause_any = |fault_cause_in;
    if (fault_cause_in[sil_pkg::CAUSE_CROSS] | (fault_cause_in[sil_pkg::CAUSE_OUT_A] &
        fault_cause_in[sil_pkg::CAUSE_OUT_B]))
      cause_code = sil_pkg::CODE_CROSS;
    else if (fault_cause_in[sil_pkg::CAUSE_OUT_A])
      cause_code = sil_pkg::CODE_OUT_A;
    else if (fault_cause_in[sil_pkg::CAUSE_OUT_B])
      cause_code = sil_pkg::CODE_OUT_B;
    else if (fault_cause_in[sil_pkg::CAUSE_TEMP])
      cause_code = sil_pkg::CODE_TEMP;
    else
      cause_code = sil_pkg::CODE_NONE;
    // fault reset sources: guard opening or falling request bit on serial units
    reset_req = ~sense_in.guard_closed |
                (serial_variant_in & q.req_prev & ~reset_request_in);
    d.req_prev = reset_request_in;
    // the enabling path; a warning alone does not cut it
    enable_path = sense_in.guard_closed & sense_in.actuator_valid & ~q.err & ~internal_fault_in &
                  (lock_coupled_variant_in ? locked : 1'b1);

    // warning supervision
    if (q.warn)
    begin
      if (!cause_any)
      begin
        d.warn = 1'b0;
        d.warn_timer = 21'h00_0000;
        d.code = sil_pkg::CODE_NONE;
      end
      else if (tick)
      begin
        if (q.warn_timer == sil_pkg::WARN_TICKS - 21'h00_0001)
        begin
          d.warn = 1'b0;
          d.err = 1'b1;
          d.warn_timer = 21'h00_0000;
        end
        else
        begin
          d.warn_timer = q.warn_timer + 21'h00_0001;
        end
      end
    end
    else if (cause_any && q.drv.safety_output_a && !q.err)
    begin
      d.warn = 1'b1;
      d.code = cause_code;
    end
    // internal fault latches at once with a steady red light
    if (internal_fault_in)
    begin
      d.err = 1'b1;
      d.warn = 1'b0;
      d.code = sil_pkg::CODE_INTERNAL;
    end
    else if (q.err && reset_req && !cause_any)
    begin
      d.err = 1'b0;
      d.code = sil_pkg::CODE_NONE;
    end

    // teach-in and anti-tamper sequence
    if (tick)
      d.timer = q.timer + 21'h00_0001;
    if (!q.started)
    begin
      // first cycle after power-up reads the persistent flags
      d.started = 1'b1;
      d.timer = 21'h00_0000;
      if (nv_inhibit_pending_in)
      begin
        d.st = sil_pkg::SIL_INHIBIT;
        d.drv.nv_inhibit_pending = 1'b1;
      end
      else if (nv_teach_pending_in)
      begin
        d.st = sil_pkg::SIL_COMMIT_WAIT;
        d.drv.nv_teach_pending = 1'b1;
      end
    end
    else
    begin
      unique case (q.st)
        sil_pkg::SIL_NORMAL:
        begin
          d.timer = 21'h00_0000;
          // unknown actuator starts teach-in unless the variant is locked down
          if (individually_coded_in && sense_in.actuator_present && !sense_in.actuator_valid &&
              (reteachable_coding_variant_in || !code_stored_in))
            d.st = sil_pkg::SIL_TEACH;
        end
        sil_pkg::SIL_TEACH:
        begin
          if (tick && q.timer == sil_pkg::TEACH_TICKS - 21'h00_0001)
          begin
            d.st = sil_pkg::SIL_OFFREQ;
            d.timer = 21'h00_0000;
            d.drv.nv_teach_pending = 1'b1;
          end
        end
        sil_pkg::SIL_OFFREQ:
        begin
          if (tick && q.timer == sil_pkg::POWEROFF_TICKS - 21'h00_0001)
          begin
            d.st = sil_pkg::SIL_ABORT;
            d.drv.nv_teach_pending = 1'b0;
          end
        end
        sil_pkg::SIL_ABORT:
        begin
          d.code = sil_pkg::CODE_ACTUATOR;
        end
        sil_pkg::SIL_COMMIT_WAIT:
        begin
          if (sense_in.actuator_present)
          begin
            d.drv.commit_code = 1'b1;
            d.drv.nv_teach_pending = 1'b0;
            d.timer = 21'h00_0000;
            if (reteachable_coding_variant_in)
            begin
              d.st = sil_pkg::SIL_INHIBIT;
              d.drv.nv_inhibit_pending = 1'b1;
            end
            else
            begin
              d.st = sil_pkg::SIL_NORMAL;
            end
          end
        end
        sil_pkg::SIL_INHIBIT:
        begin
          // hold at the end of the period until the new actuator shows up
          if (q.timer >= sil_pkg::INHIBIT_TICKS)
          begin
            d.timer = sil_pkg::INHIBIT_TICKS;
            if (sense_in.actuator_valid)
            begin
              d.st = sil_pkg::SIL_NORMAL;
              d.drv.nv_inhibit_pending = 1'b0;
            end
          end
        end
        default:
        begin
          d.st = sil_pkg::SIL_ABORT;
        end
      endcase
    end

    // solenoid drive, refused while the handle sits between positions
    d.drv.solenoid_lock = want_lock & sense_in.handle_ok;

    // safety and diagnostic outputs
    if (q.st == sil_pkg::SIL_NORMAL && q.started)
    begin
      d.drv.safety_output_a = enable_path & ~d.err;
      d.drv.safety_output_b = enable_path & ~d.err;
      d.drv.diag = sense_in.guard_closed & sense_in.actuator_valid & ~handle_bad_req &
                   ~q.warn & ~cause_any & ~q.err & ~internal_fault_in;
    end
    else
    begin
      d.drv.safety_output_a = 1'b0;
      d.drv.safety_output_b = 1'b0;
      d.drv.diag = 1'b0;
    end

    // red blink pattern: n pulses per frame, then a pause
    red_code = (q.slot_idx < q.code) && (q.slot_ms < sil_pkg::SLOT_ON);
    if (frame_end)
      d.slot_idx = 3'h0;

    // indicators
    unique case (q.st)
      sil_pkg::SIL_TEACH, sil_pkg::SIL_COMMIT_WAIT:
      begin
        d.drv.led_power = 1'b0;
        d.drv.led_fault = 1'b1;
        d.drv.led_status = q.ms_1hz < sil_pkg::HZ1_ON;
      end
      sil_pkg::SIL_OFFREQ:
      begin
        d.drv.led_power = 1'b0;
        d.drv.led_fault = 1'b1;
        d.drv.led_status = q.ms_3hz < sil_pkg::HZ3_ON;
      end
      sil_pkg::SIL_ABORT:
      begin
        d.drv.led_power = 1'b1;
        d.drv.led_fault = red_code;
        d.drv.led_status = 1'b0;
      end
      sil_pkg::SIL_INHIBIT:
      begin
        d.drv.led_power = q.ms_1hz < sil_pkg::HZ1_ON;
        d.drv.led_fault = 1'b0;
        d.drv.led_status = 1'b0;
      end
      default:
      begin
        d.drv.led_power = 1'b1;
        if (q.err || q.warn)
        begin
          // steady for internal faults, pulse count otherwise
          d.drv.led_fault = (q.code == sil_pkg::CODE_INTERNAL) ? 1'b1 : red_code;
          d.drv.led_status = 1'b0;
        end
        else if (handle_bad_req && sense_in.guard_closed)
        begin
          // locking impossible: shown as handle code without latching an error
          d.drv.led_fault = (q.slot_idx < sil_pkg::CODE_HANDLE) && (q.slot_ms < sil_pkg::SLOT_ON);
          d.drv.led_status = q.ms_1hz < sil_pkg::HZ1_ON;
        end
        else
        begin
          d.drv.led_fault = 1'b0;
          if (!sense_in.guard_closed)
            d.drv.led_status = 1'b0;
          else if (locked)
            d.drv.led_status = 1'b1;
          else
            d.drv.led_status = q.ms_1hz < sil_pkg::HZ1_ON;
        end
      end
    endcase
  end

  // state register; power-up is the only full restart
  always_ff @(posedge clock_in)
  begin
    if (!rst_n_in)
      q <= '0;
    else
      q <= d;
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  unlock_decode_a: assert property (sense_in.handle_ok && !power_to_lock_variant_in && lock_cmd_in
    |=> !drive_out.solenoid_lock) else $error("unlock command did not release");
  lock_decode_a: assert property (sense_in.handle_ok && power_to_lock_variant_in && lock_cmd_in
    |=> drive_out.solenoid_lock) else $error("lock command did not engage");
  handle_block_a: assert property (!sense_in.handle_ok |=> !drive_out.solenoid_lock)
    else $error("locked with handle between positions");
  guard_open_a: assert property (!sense_in.guard_closed |=>
    !drive_out.safety_output_a && !drive_out.safety_output_b && !drive_out.diag)
    else $error("outputs high with guard open");
  internal_drop_a: assert property (internal_fault_in |=> !drive_out.safety_output_a &&
    !drive_out.safety_output_b) else $error("internal fault left outputs on");
  coupled_drop_a: assert property (lock_coupled_variant_in && !sense_in.lock_engaged
    |=> !drive_out.safety_output_a) else $error("unlocked coupled unit kept output");
  warn_diag_a: assert property ($rose(q.warn) |-> !drive_out.diag ##1 !drive_out.diag)
    else $error("diag high during warning");
  teach_leds_a: assert property (q.st == sil_pkg::SIL_TEACH && $stable(q.st)
    |-> !drive_out.led_power && drive_out.led_fault) else $error("teach indication wrong");
  abort_entry_a: assert property (q.st == sil_pkg::SIL_OFFREQ && tick &&
    q.timer == sil_pkg::POWEROFF_TICKS - 21'h00_0001 |=> q.st == sil_pkg::SIL_ABORT)
    else $error("teach not aborted at power-off limit");
  inhibit_hold_a: assert property (q.st == sil_pkg::SIL_INHIBIT |=> !drive_out.safety_output_a)
    else $error("output on during inhibit");
  commit_src_a: assert property (drive_out.commit_code |-> $past(q.st) == sil_pkg::SIL_COMMIT_WAIT)
    else $error("commit outside commit wait");

endmodule : sil_controller

// File: bench/sil_partner_model.sv
// storage and bolt model standing in for the far side of the interlock controller
`timescale 1ns/1ps
module sil_partner_model (
  // clock and power
  input wire logic clock_in,
  input wire logic rst_n_in,
  // controller drives and door state
  input wire sil_pkg::sil_drive_t drive_in,
  input wire logic guard_closed_in,
  input wire logic wipe_in,
  // fed back to the controller
  output logic lock_engaged_out,
  output logic code_stored_out,
  output logic nv_teach_pending_out,
  output logic nv_inhibit_pending_out
);
  // edges since power returned; drives carry live values only from the second one
  logic [1:0] live_cnt = 2'h0;

  // storage survives reset, as non-volatile memory does
  initial
  begin
    code_stored_out = 1'h0;
    nv_teach_pending_out = 1'h0;
    nv_inhibit_pending_out = 1'h0;
    lock_engaged_out = 1'h0;
  end

  // bolt follows the solenoid only while the door is shut; storage is written back
  always @(posedge clock_in)
  begin
    lock_engaged_out <= drive_in.solenoid_lock & guard_closed_in;
    if (!rst_n_in)
      live_cnt <= 2'h0;
    else if (live_cnt != 2'h2)
      live_cnt <= live_cnt + 2'h1;
    if (wipe_in)
    begin
      // models a service wipe of the pending flags only
      nv_teach_pending_out <= 1'h0;
      nv_inhibit_pending_out <= 1'h0;
    end
    else if (rst_n_in && live_cnt == 2'h2)
    begin
      // only live drives are stored, so the zeros of reset never erase a flag
      nv_teach_pending_out <= drive_in.nv_teach_pending;
      nv_inhibit_pending_out <= drive_in.nv_inhibit_pending;
      if (drive_in.commit_code)
        code_stored_out <= 1'h1;
    end
  end
endmodule : sil_partner_model

// File: bench/safety_interlock_controller_tb.sv
// self-checking bench for the safety interlock controller
`timescale 1ns/1ps
module safety_interlock_controller_tb;
  // short tick keeps the ten second teach window near 20000 cycles
  localparam int TICK = 2;
  localparam int FRAME = int'(sil_pkg::SLOT_PERIOD) * 8 * TICK;
  localparam int P1HZ = int'(sil_pkg::HZ1_PERIOD) * TICK;
  localparam int TEACH = int'(sil_pkg::TEACH_TICKS) * TICK;
  // clock, power and straps
  logic clock = 1'h0;
  logic rst_n = 1'h0;
  logic to_lock = 1'h0;
  logic coupled = 1'h1;
  logic coded = 1'h0;
  logic reteach = 1'h0;
  logic serial = 1'h0;
  // command, sensors and faults
  logic lock_cmd = 1'h0;
  logic guard = 1'h1;
  logic present = 1'h1;
  logic valid = 1'h1;
  logic handle = 1'h1;
  logic [3:0] cause = 4'h0;
  logic internal = 1'h0;
  logic req = 1'h0;
  logic wipe = 1'h0;
  // partner feedback and design drives
  logic lock_eng;
  logic stored;
  logic nv_teach;
  logic nv_inhibit;
  sil_pkg::sil_sense_t sense;
  sil_pkg::sil_drive_t drv;
  // bookkeeping
  int errors = 0;
  int n_tests = 0;
  int hi_cnt;
  int rise_cnt;

  assign sense = {guard, present, valid, lock_eng, handle};

  // 100 MHz clock
  initial
  begin
    forever #5 clock = ~clock;
  end

  sil_controller #(.TICK_CYCLES(TICK)) dut (
    .clock_in(clock), .rst_n_in(rst_n), .power_to_lock_variant_in(to_lock),
    .lock_coupled_variant_in(coupled), .individually_coded_in(coded),
    .reteachable_coding_variant_in(reteach), .serial_variant_in(serial), .lock_cmd_in(lock_cmd),
    .sense_in(sense), .fault_cause_in(cause), .internal_fault_in(internal), .reset_request_in(req),
    .code_stored_in(stored), .nv_teach_pending_in(nv_teach), .nv_inhibit_pending_in(nv_inhibit),
    .drive_out(drv));

  sil_partner_model partner (
    .clock_in(clock), .rst_n_in(rst_n), .drive_in(drv), .guard_closed_in(guard), .wipe_in(wipe),
    .lock_engaged_out(lock_eng), .code_stored_out(stored), .nv_teach_pending_out(nv_teach),
    .nv_inhibit_pending_out(nv_inhibit));

  // one comparison, counted
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check

  task automatic wait_cyc(input int n);
    repeat (n) @(negedge clock);
  endtask : wait_cyc

  // samples one drive bit for n cycles: time high and rising edges
  task automatic count_bit(input int n, input int idx);
    logic prev;
    prev = drv[idx];
    hi_cnt = 0;
    rise_cnt = 0;
    repeat (n)
    begin
      @(negedge clock);
      hi_cnt += int'(drv[idx] === 1'h1);
      rise_cnt += int'(drv[idx] === 1'h1 && prev === 1'h0);
      prev = drv[idx];
    end
  endtask : count_bit

  task automatic power_cycle;
    rst_n = 1'h0;
    wait_cyc(12);
    rst_n = 1'h1;
    wait_cyc(3);
  endtask : power_cycle

  // door opened and shut again with the actuator
  task automatic cycle_guard;
    guard = 1'h0;
    present = 1'h0;
    wait_cyc(6);
    guard = 1'h1;
    present = 1'h1;
    wait_cyc(8);
  endtask : cycle_guard

  task automatic t_magnet;
    for (int v = 0; v < 2; v++)
    begin
      for (int c = 0; c < 2; c++)
      begin
        to_lock = v[0];
        lock_cmd = c[0];
        wait_cyc(4);
        check("solenoid", drv.solenoid_lock, (c == v));
      end
    end
    to_lock = 1'h0;
    lock_cmd = 1'h0;
    wait_cyc(6);
    $display("test magnet finished");
  endtask : t_magnet

  task automatic t_states;
    for (int c = 0; c < 2; c++)
    begin
      coupled = c[0];
      guard = 1'h0;
      present = 1'h0;
      wait_cyc(6);
      check("open outputs", {drv.safety_output_a, drv.safety_output_b, drv.diag}, 3'h0);
      guard = 1'h1;
      present = 1'h1;
      lock_cmd = 1'h1;
      wait_cyc(6);
      check("unlocked outputs", {drv.safety_output_a, drv.safety_output_b}, {2{~c[0]}});
      check("unlocked diag", drv.diag, 1'h1);
      lock_cmd = 1'h0;
      wait_cyc(6);
      check("locked outputs", {drv.safety_output_a, drv.safety_output_b, drv.diag}, 3'h7);
      count_bit(500, 4);
      check("status steady", hi_cnt, 500);
    end
    $display("test states finished");
  endtask : t_states

  task automatic t_handle;
    lock_cmd = 1'h1;
    wait_cyc(4);
    handle = 1'h0;
    lock_cmd = 1'h0;
    wait_cyc(6);
    check("handle lock", {drv.solenoid_lock, drv.diag, drv.safety_output_a}, 3'h0);
    count_bit(FRAME, 3);
    check("handle code", rise_cnt, 6);
    handle = 1'h1;
    wait_cyc(8);
    check("handle restored", drv.safety_output_a, 1'h1);
    $display("test handle finished");
  endtask : t_handle

  // each minor cause warns with its own pulse count and clears itself
  task automatic t_warn;
    for (int i = 0; i < 4; i++)
    begin
      cause = 4'h1 << i;
      wait_cyc(4);
      check("warn outputs", {drv.safety_output_a, drv.safety_output_b, drv.diag, drv.led_status}, 4'hc);
      count_bit(FRAME, 3);
      check("warn code", rise_cnt, i + 1);
      cause = 4'h0;
      wait_cyc(6);
      check("warn cleared", {drv.safety_output_a, drv.diag}, 2'h3);
    end
    $display("test warn finished");
  endtask : t_warn

  task automatic t_internal;
    internal = 1'h1;
    wait_cyc(3);
    check("internal drop", {drv.safety_output_a, drv.safety_output_b}, 2'h0);
    count_bit(500, 3);
    check("internal steady", hi_cnt, 500);
    cycle_guard();
    check("reset refused", drv.safety_output_a, 1'h0);
    internal = 1'h0;
    wait_cyc(6);
    check("error latched", drv.safety_output_a, 1'h0);
    cycle_guard();
    check("guard reset", drv.safety_output_a, 1'h1);
    $display("test internal finished");
  endtask : t_internal

  task automatic t_serial;
    serial = 1'h1;
    req = 1'h1;
    internal = 1'h1;
    wait_cyc(4);
    internal = 1'h0;
    wait_cyc(4);
    check("serial latched", drv.safety_output_a, 1'h0);
    req = 1'h0;
    wait_cyc(6);
    check("serial reset", drv.safety_output_a, 1'h1);
    serial = 1'h0;
    $display("test serial finished");
  endtask : t_serial

  task automatic t_teach;
    coded = 1'h1;
    reteach = 1'h1;
    present = 1'h0;
    valid = 1'h0;
    power_cycle();
    present = 1'h1;
    wait_cyc(4);
    check("teach leds", {drv.led_power, drv.led_fault}, 2'h1);
    count_bit(P1HZ, 4);
    check("teach 1hz", rise_cnt, 1);
    wait_cyc(TEACH - 100 - 4 - P1HZ);
    check("teach early", drv.nv_teach_pending, 1'h0);
    wait_cyc(300);
    check("offreq", drv.nv_teach_pending, 1'h1);
    count_bit(int'(sil_pkg::HZ3_PERIOD) * TICK * 3, 4);
    check("offreq 3hz", rise_cnt, 3);
    present = 1'h0;
    power_cycle();
    present = 1'h1;
    count_bit(10, 2);
    check("commit pulse", rise_cnt, 1);
    valid = 1'h1;
    wait_cyc(4);
    check("inhibit", {drv.nv_inhibit_pending, drv.safety_output_a}, 2'h2);
    count_bit(P1HZ, 5);
    check("inhibit blink", rise_cnt, 1);
    power_cycle();
    wait_cyc(4);
    check("inhibit restart", {drv.nv_inhibit_pending, drv.safety_output_a}, 2'h2);
    $display("test teach finished");
  endtask : t_teach

  task automatic t_onetime;
    wipe = 1'h1;
    wait_cyc(2);
    wipe = 1'h0;
    reteach = 1'h0;
    present = 1'h0;
    valid = 1'h0;
    power_cycle();
    present = 1'h1;
    wait_cyc(6);
    check("code kept", stored, 1'h1);
    check("teach refused", drv.led_power, 1'h1);
    $display("test onetime finished");
  endtask : t_onetime

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : final_report

  // watchdog sized well above the roughly 60000 cycles the tests take
  initial
  begin
    repeat (90000) @(posedge clock);
    errors++;
    final_report();
  end

  // main sequence
  initial
  begin
    wait_cyc(12);
    check("reset drives", drv, 10'h000);
    rst_n = 1'h1;
    wait_cyc(1);
    check("first edge drives", drv, 10'h070);
    wait_cyc(6);
    t_magnet();
    t_states();
    t_handle();
    t_warn();
    t_internal();
    t_serial();
    t_teach();
    t_onetime();
    final_report();
  end
endmodule : safety_interlock_controller_tb
